// ### rtl/ccf_cfg.svh
/*
 * Offsets, field positions and reset values of the counter command and fault block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH

`define CCF_ADDR_W        5
`define CCF_OFS_VALUE     5'h00
`define CCF_OFS_CTRL      5'h04
`define CCF_OFS_STATUS    5'h08
`define CCF_OFS_COUNT     5'h0C
`define CCF_OFS_PRELOAD   5'h10
`define CCF_OFS_CMP_ONE   5'h14
`define CCF_OFS_CMP_TWO   5'h18
`define CCF_OFS_OUT_PARAM 5'h1C

// control word fields
`define CCF_C_GATE        0
`define CCF_C_SYNC_EN     1
`define CCF_C_CLR_REQ     2
`define CCF_C_LVL_ONE     3
`define CCF_C_EN_ONE      4
`define CCF_C_LVL_TWO     5
`define CCF_C_EN_TWO      6
`define CCF_C_ERR_ACK     7
`define CCF_C_CMD_LSB     8
`define CCF_C_DIAG_EN     16
`define CCF_CTRL_MASK     32'h0001_1FFF

// command bit index inside the five-bit command field
`define CCF_CMD_DIRECT    0
`define CCF_CMD_PRELOAD   1
`define CCF_CMD_CMP_ONE   2
`define CCF_CMD_CMP_TWO   3
`define CCF_CMD_PARAM     4

// status word fields
`define CCF_S_SUPPLY      0
`define CCF_S_OUT_ONE_F   1
`define CCF_S_OUT_TWO_F   2
`define CCF_S_ENCODER     3
`define CCF_S_LOAD_ERR    4
`define CCF_S_PARAM_ERR   5
`define CCF_S_CLR_ACT     6
`define CCF_S_CMP_ONE     7
`define CCF_S_CMP_TWO     8
`define CCF_S_SYNC        9
`define CCF_S_OUT_ONE     10
`define CCF_S_OUT_TWO     11
`define CCF_S_GATE        12

`define CCF_RESET_WORD    32'h0000_0000
`define CCF_RESP_OKAY     2'b00
`define CCF_RESP_SLVERR   2'b10

`endif

// ### rtl/ccf_pkg.sv
/*
 * Types of the counter command and fault block.
 * Assumes nothing beyond the constants header.
 */
package ccf_pkg;
  typedef enum logic [2:0] {
    CCF_FN_PLAIN   = 3'h0,
    CCF_FN_AT_LEAST = 3'h1,
    CCF_FN_AT_MOST = 3'h2,
    CCF_FN_PULSE   = 3'h3,
    CCF_FN_BETWEEN = 3'h4
  } ccf_out_fn_type;

  typedef logic [4:0] ccf_cmd_type;
endpackage

// ### rtl/ccf_top.sv
/*
 * Command-bit and fault-flag handling of a counter module, reached over AXI4-Lite.
 * Assumes the counting core, comparators and fault sensing sit outside and
 * present synchronous levels on the fault and comparator inputs.
 */
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ccf_cfg.svh"

module ccf_top
  import ccf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [4:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [4:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_supply_short,
  input  wire logic        i_out_one_fault_src,
  input  wire logic        i_out_two_fault_src,
  input  wire logic        i_encoder_fault_src,
  input  wire logic        i_cmp_one_on,
  input  wire logic        i_cmp_two_on,
  input  wire logic        i_sync_event,
  output logic             o_output_one,
  output logic             o_output_two,
  output logic             o_software_gate,
  output logic             o_sync_enable,
  output logic             o_count_load,
  output logic [31:0]      o_count_value,
  output logic [31:0]      o_preload_value,
  output logic [31:0]      o_compare_one,
  output logic [31:0]      o_compare_two,
  output logic [23:0]      o_out_param,
  output logic             o_diag_event
);

  logic [31:0] value_ff;
  logic [31:0] ctrl_ff;
  logic [4:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  ccf_cmd_type cmd_prev_ff;
  logic        clr_req_prev_ff;
  logic        clr_active_ff;
  logic [3:0]  fault_ff;
  logic        load_err_ff;
  logic        param_err_ff;
  logic        cmp_one_flag_ff;
  logic        cmp_two_flag_ff;
  logic        sync_flag_ff;

  // bytewise merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic addr_known(input logic [4:0] a);
    return a[1:0] == 2'b00;
  endfunction

  // ---------------- bus write side
  logic do_write;
  assign o_awready = !aw_got_ff && !o_bvalid;
  assign o_wready  = !w_got_ff && !o_bvalid;
  assign do_write  = aw_got_ff && w_got_ff;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 5'h00;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_got_ff  <= 1'b1;
      aw_addr_ff <= i_awaddr;
    end
    else if (do_write)
      aw_got_ff <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      w_got_ff  <= 1'b0;
      w_data_ff <= `CCF_RESET_WORD;
      w_strb_ff <= 4'h0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_got_ff  <= 1'b1;
      w_data_ff <= i_wdata;
      w_strb_ff <= i_wstrb;
    end
    else if (do_write)
      w_got_ff <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= `CCF_RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= (aw_addr_ff == `CCF_OFS_VALUE || aw_addr_ff == `CCF_OFS_CTRL)
                  ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      value_ff <= `CCF_RESET_WORD;
      ctrl_ff  <= `CCF_RESET_WORD;
    end
    else if (do_write)
    begin
      if (aw_addr_ff == `CCF_OFS_VALUE)
        value_ff <= merge(value_ff, w_data_ff, w_strb_ff);
      if (aw_addr_ff == `CCF_OFS_CTRL)
        ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & `CCF_CTRL_MASK;
    end
  end

  // ---------------- commands
  ccf_cmd_type cmd_lvl;
  ccf_cmd_type cmd_rise;
  logic        cmd_clash;
  logic        param_bad;
  assign cmd_lvl   = ctrl_ff[`CCF_C_CMD_LSB +: 5];
  assign cmd_rise  = cmd_lvl & ~cmd_prev_ff;
  assign cmd_clash = (cmd_rise != 5'h00) && !$onehot(cmd_lvl);
  // between-values needs a proper window; reserved codes are refused as well
  assign param_bad = (value_ff[2:0] == CCF_FN_BETWEEN && o_compare_two <= o_compare_one)
                     || value_ff[2:0] > CCF_FN_BETWEEN;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cmd_prev_ff <= 5'h00;
    else
      cmd_prev_ff <= cmd_lvl;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_count_value   <= `CCF_RESET_WORD;
      o_preload_value <= `CCF_RESET_WORD;
      o_compare_one   <= `CCF_RESET_WORD;
      o_compare_two   <= `CCF_RESET_WORD;
      o_out_param     <= 24'h000000;
      o_count_load    <= 1'b0;
    end
    else
    begin
      o_count_load <= cmd_rise[`CCF_CMD_DIRECT] && !cmd_clash;
      if (!cmd_clash)
      begin
        if (cmd_rise[`CCF_CMD_DIRECT])
          o_count_value <= value_ff;
        if (cmd_rise[`CCF_CMD_PRELOAD])
          o_preload_value <= value_ff;
        if (cmd_rise[`CCF_CMD_CMP_ONE])
          o_compare_one <= value_ff;
        if (cmd_rise[`CCF_CMD_CMP_TWO])
          o_compare_two <= value_ff;
        if (cmd_rise[`CCF_CMD_PARAM] && !param_bad)
          o_out_param <= value_ff[23:0];
      end
    end
  end

  // ---------------- errors; a new cause wins over an acknowledge in the same cycle
  logic [3:0] fault_src;
  logic       ack;
  logic [3:0] fault_new;
  assign fault_src = {i_encoder_fault_src, i_out_two_fault_src, i_out_one_fault_src,
                      i_supply_short};
  assign ack       = ctrl_ff[`CCF_C_ERR_ACK];
  assign fault_new = fault_src & ~fault_ff;

  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_fault
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          fault_ff[g] <= 1'b0;
        else if (fault_src[g])
          fault_ff[g] <= 1'b1;
        else if (ack)
          fault_ff[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      load_err_ff  <= 1'b0;
      param_err_ff <= 1'b0;
    end
    else
    begin
      if (cmd_clash)
        load_err_ff <= 1'b1;
      else if (ack)
        load_err_ff <= 1'b0;
      if (cmd_rise[`CCF_CMD_PARAM] && !cmd_clash && param_bad)
        param_err_ff <= 1'b1;
      else if (ack)
        param_err_ff <= 1'b0;
    end
  end

  // only a supply fault is reported as a diagnostic event
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_diag_event <= 1'b0;
    else
      o_diag_event <= fault_new[`CCF_S_SUPPLY] && ctrl_ff[`CCF_C_DIAG_EN];
  end

  // ---------------- status clear handshake
  logic clr_req;
  logic clr_pulse;
  assign clr_req   = ctrl_ff[`CCF_C_CLR_REQ];
  assign clr_pulse = clr_req && !clr_req_prev_ff;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clr_req_prev_ff <= 1'b0;
      clr_active_ff   <= 1'b0;
    end
    else
    begin
      clr_req_prev_ff <= clr_req;
      clr_active_ff   <= clr_req;
    end
  end

  // comparator flags re-set at once while the output still stands
  logic cmp_one_set;
  logic cmp_two_set;
  assign cmp_one_set = i_cmp_one_on || o_output_one
                       || (ctrl_ff[`CCF_C_LVL_ONE] && !ctrl_ff[`CCF_C_EN_ONE]);
  assign cmp_two_set = i_cmp_two_on || o_output_two
                       || (ctrl_ff[`CCF_C_LVL_TWO] && !ctrl_ff[`CCF_C_EN_TWO]);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cmp_one_flag_ff <= 1'b0;
      cmp_two_flag_ff <= 1'b0;
      sync_flag_ff    <= 1'b0;
    end
    else
    begin
      if (cmp_one_set)
        cmp_one_flag_ff <= 1'b1;
      else if (clr_pulse)
        cmp_one_flag_ff <= 1'b0;
      if (cmp_two_set)
        cmp_two_flag_ff <= 1'b1;
      else if (clr_pulse)
        cmp_two_flag_ff <= 1'b0;
      if (i_sync_event && ctrl_ff[`CCF_C_SYNC_EN])
        sync_flag_ff <= 1'b1;
      else if (clr_pulse)
        sync_flag_ff <= 1'b0;
    end
  end

  // ---------------- outputs
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_output_one    <= 1'b0;
      o_output_two    <= 1'b0;
      o_software_gate <= 1'b0;
      o_sync_enable   <= 1'b0;
    end
    else
    begin
      o_output_one    <= ctrl_ff[`CCF_C_EN_ONE] && ctrl_ff[`CCF_C_LVL_ONE];
      o_output_two    <= ctrl_ff[`CCF_C_EN_TWO] && ctrl_ff[`CCF_C_LVL_TWO];
      o_software_gate <= ctrl_ff[`CCF_C_GATE];
      o_sync_enable   <= ctrl_ff[`CCF_C_SYNC_EN];
    end
  end

  // ---------------- bus read side
  logic [31:0] status_word;
  always_comb
  begin
    status_word = `CCF_RESET_WORD;
    status_word[`CCF_S_ENCODER:`CCF_S_SUPPLY] = fault_ff;
    status_word[`CCF_S_LOAD_ERR]  = load_err_ff;
    status_word[`CCF_S_PARAM_ERR] = param_err_ff;
    status_word[`CCF_S_CLR_ACT]   = clr_active_ff;
    status_word[`CCF_S_CMP_ONE]   = cmp_one_flag_ff;
    status_word[`CCF_S_CMP_TWO]   = cmp_two_flag_ff;
    status_word[`CCF_S_SYNC]      = sync_flag_ff;
    status_word[`CCF_S_OUT_ONE]   = o_output_one;
    status_word[`CCF_S_OUT_TWO]   = o_output_two;
    status_word[`CCF_S_GATE]      = o_software_gate;
  end

  assign o_arready = !o_rvalid;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= `CCF_RESET_WORD;
      o_rresp  <= `CCF_RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= addr_known(i_araddr) ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
      unique case (i_araddr)
        `CCF_OFS_VALUE:     o_rdata <= value_ff;
        `CCF_OFS_CTRL:      o_rdata <= ctrl_ff;
        `CCF_OFS_STATUS:    o_rdata <= status_word;
        `CCF_OFS_COUNT:     o_rdata <= o_count_value;
        `CCF_OFS_PRELOAD:   o_rdata <= o_preload_value;
        `CCF_OFS_CMP_ONE:   o_rdata <= o_compare_one;
        `CCF_OFS_CMP_TWO:   o_rdata <= o_compare_two;
        `CCF_OFS_OUT_PARAM: o_rdata <= {8'h00, o_out_param};
        default:            o_rdata <= `CCF_RESET_WORD;
      endcase
    end
    else if (i_rready)
      o_rvalid <= 1'b0;
  end

  // ---------------- checks
  sequence s_single_cmd(int b);
    cmd_rise[b] && !cmd_clash;
  endsequence

  a_direct_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_single_cmd(`CCF_CMD_DIRECT) |=> o_count_value == $past(value_ff) && o_count_load)
    else $error("direct load not applied");
  a_preload_keep: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_single_cmd(`CCF_CMD_PRELOAD) |=> o_preload_value == $past(value_ff)
    && $stable(o_count_value))
    else $error("preload wrong or count moved");
  a_cmp_one_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_single_cmd(`CCF_CMD_CMP_ONE) |=> o_compare_one == $past(value_ff))
    else $error("compare one not loaded");
  a_cmp_two_load: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_single_cmd(`CCF_CMD_CMP_TWO) |=> o_compare_two == $past(value_ff))
    else $error("compare two not loaded");
  a_clash_rejects: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cmd_clash |=> load_err_ff && $stable(o_count_value) && $stable(o_compare_one))
    else $error("clashing commands accepted");
  a_out_one_follow: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 o_output_one == $past(ctrl_ff[`CCF_C_EN_ONE] && ctrl_ff[`CCF_C_LVL_ONE]))
    else $error("output one wrong");
  a_out_two_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ctrl_ff[`CCF_C_EN_TWO] |=> !o_output_two)
    else $error("output two on while disabled");
  a_fault_sticky: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fault_ff[`CCF_S_SUPPLY] && !ack |=> fault_ff[`CCF_S_SUPPLY])
    else $error("supply fault dropped without acknowledge");
  a_clear_answer: assert property (@(posedge i_clk) disable iff (!i_rstn)
    clr_pulse |=> clr_active_ff)
    else $error("clear request not answered");
  a_cmp_reset_back: assert property (@(posedge i_clk) disable iff (!i_rstn)
    clr_pulse && o_output_one |=> cmp_one_flag_ff)
    else $error("comparator flag lost while output on");

endmodule

`default_nettype wire

// ### test/ccf_host_model.sv
/*
 * Host-side model: an AXI4-Lite master that writes control words and reads feedback.
 * Assumes one clock shared with the slave and a reset held by the bench before first use.
 */
`timescale 1ns/100ps
`default_nettype none

module ccf_host_model
(
  input  wire logic        i_clk,
  output logic [4:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic [3:0]       o_wstrb,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [4:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  initial
  begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
  end

  // starts one edge late so a release from the previous call never shares a time step
  task automatic write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r,
                       output bit ok);
    int n;
    begin
      @(posedge i_clk);
      ok = 1'b0;
      r = 2'h3;
      o_awaddr <= a;
      o_awvalid <= 1'b1;
      o_wdata <= d;
      o_wstrb <= 4'hF;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      for (n = 0; n < 64 && !ok; n++)
      begin
        @(posedge i_clk);
        if (o_awvalid && i_awready)
          o_awvalid <= 1'b0;
        if (o_wvalid && i_wready)
          o_wvalid <= 1'b0;
        if (i_bvalid)
        begin
          r = i_bresp;
          ok = 1'b1;
          o_bready <= 1'b0;
        end
      end
    end
  endtask

  task automatic read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r,
                      output bit ok);
    int n;
    begin
      @(posedge i_clk);
      ok = 1'b0;
      d = '0;
      r = 2'h3;
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      for (n = 0; n < 64 && !ok; n++)
      begin
        @(posedge i_clk);
        if (o_arvalid && i_arready)
          o_arvalid <= 1'b0;
        if (i_rvalid)
        begin
          d = i_rdata;
          r = i_rresp;
          ok = 1'b1;
          o_rready <= 1'b0;
        end
      end
    end
  endtask
endmodule

`default_nettype wire

// ### test/tb.sv
/*
 * Self-checking bench of the counter command and fault block.
 * Assumes the host model drives the register bus and the bench plays the counting core.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccf_cfg.svh"

`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module tb;
  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sync_ev, out_one, out_two, gate;
  logic        sync_en, count_load, diag;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, count_v, pre_v, cmp1_v, cmp2_v;
  logic [3:0]  wstrb, src;
  logic [1:0]  bresp, rresp, cmp_on;
  logic [23:0] out_param;
  int          n_errors, num_checks, n_load, n_diag;

  ccf_top ccf_top_i (.i_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_supply_short(src[0]),
    .i_out_one_fault_src(src[1]), .i_out_two_fault_src(src[2]),
    .i_encoder_fault_src(src[3]), .i_cmp_one_on(cmp_on[0]), .i_cmp_two_on(cmp_on[1]),
    .i_sync_event(sync_ev), .o_output_one(out_one), .o_output_two(out_two),
    .o_software_gate(gate), .o_sync_enable(sync_en), .o_count_load(count_load),
    .o_count_value(count_v), .o_preload_value(pre_v), .o_compare_one(cmp1_v),
    .o_compare_two(cmp2_v), .o_out_param(out_param), .o_diag_event(diag));

  ccf_host_model ccf_host_model_i (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses are counted where they stand, a read afterwards would miss them
  always @(posedge clk)
  begin
    if (count_load === 1'b1)
      n_load++;
    if (diag === 1'b1)
      n_diag++;
  end

  task automatic summarize();
    begin
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    begin
      ccf_host_model_i.write(a, d, r, ok);
      `CHK("write answer", 1'b1, ok)
      if (!ok)
        summarize();
      `CHK("bresp", er, r)
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    begin
      ccf_host_model_i.read(a, d, r, ok);
      `CHK("read answer", 1'b1, ok)
      if (!ok)
        summarize();
      `CHK("rresp", er, r)
    end
  endtask

  task automatic t_reset();
    logic [31:0] d;
    begin
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("status", 32'h0000_0000, d)
      rd(5'h02, d, `CCF_RESP_SLVERR);
      `CHK("unaligned", 32'h0000_0000, d)
      wr(`CCF_OFS_COUNT, 32'h1234_5678, `CCF_RESP_SLVERR);
      rd(`CCF_OFS_COUNT, d, `CCF_RESP_OKAY);
      `CHK("count", 32'h0000_0000, d)
      $display("done reset");
    end
  endtask

  task automatic t_loads();
    logic [4:0]  ofs [4] = '{`CCF_OFS_COUNT, `CCF_OFS_PRELOAD, `CCF_OFS_CMP_ONE,
                             `CCF_OFS_CMP_TWO};
    logic [31:0] v, d;
    begin
      for (int k = 0; k < 4; k++)
      begin
        v = 32'hA5C3_0F10 ^ 32'(k);
        wr(`CCF_OFS_VALUE, v, `CCF_RESP_OKAY);
        wr(`CCF_OFS_CTRL, 32'h0000_0100 << k, `CCF_RESP_OKAY);
        // a new value while the command bit still stands must not be taken
        wr(`CCF_OFS_VALUE, ~v, `CCF_RESP_OKAY);
        rd(ofs[k], d, `CCF_RESP_OKAY);
        `CHK("loaded", v, d)
        wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      end
      rd(`CCF_OFS_COUNT, d, `CCF_RESP_OKAY);
      `CHK("count kept", 32'hA5C3_0F10, d)
      `CHK("load pulses", 1, n_load)
      `CHK("count port", 32'hA5C3_0F10, count_v)
      // two commands in one write
      wr(`CCF_OFS_VALUE, 32'h7777_0000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0300, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("load error", 1'b1, d[`CCF_S_LOAD_ERR])
      rd(`CCF_OFS_COUNT, d, `CCF_RESP_OKAY);
      `CHK("count clash", 32'hA5C3_0F10, d)
      $display("done loads");
    end
  endtask

  task automatic t_param();
    logic [31:0] d;
    begin
      // compare two is above compare one here, so the between-values code is legal
      wr(`CCF_OFS_VALUE, 32'hFF11_2224, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_1000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      rd(`CCF_OFS_OUT_PARAM, d, `CCF_RESP_OKAY);
      `CHK("param", 32'h0011_2224, d)
      `CHK("param port", 24'h11_2224, out_param)
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("param ok", 1'b0, d[`CCF_S_PARAM_ERR])
      wr(`CCF_OFS_VALUE, 32'h0000_0000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0800, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_VALUE, 32'h0033_4404, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_1000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      rd(`CCF_OFS_OUT_PARAM, d, `CCF_RESP_OKAY);
      `CHK("param kept", 32'h0011_2224, d)
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("param error", 1'b1, d[`CCF_S_PARAM_ERR])
      wr(`CCF_OFS_CTRL, 32'h0000_0080, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("errors acked", 2'b00, d[5:4])
      // reserved function codes are refused as well
      wr(`CCF_OFS_VALUE, 32'h0000_0005, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_1000, `CCF_RESP_OKAY);
      wr(`CCF_OFS_CTRL, 32'h0000_0000, `CCF_RESP_OKAY);
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("reserved code", 1'b1, d[`CCF_S_PARAM_ERR])
      rd(`CCF_OFS_OUT_PARAM, d, `CCF_RESP_OKAY);
      `CHK("reserved kept", 32'h0011_2224, d)
      $display("done param");
    end
  endtask

  task automatic t_outputs();
    logic [31:0] d;
    begin
      for (int i = 0; i < 16; i++)
      begin
        wr(`CCF_OFS_CTRL, {25'h0, i[3:0], 1'b0, i[2], i[1]}, `CCF_RESP_OKAY);
        rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
        `CHK("out one", i[1] & i[0], out_one)
        `CHK("out two", i[3] & i[2], out_two)
        `CHK("gate", i[1], gate)
        `CHK("sync en", i[2], sync_en)
        `CHK("out status", {i[1], i[3] & i[2], i[1] & i[0]}, d[12:10])
      end
      $display("done outputs");
    end
  endtask

  task automatic t_flags();
    logic [31:0] d;
    begin
      for (int e = 0; e < 2; e++)
      begin
        wr(`CCF_OFS_CTRL, {30'h0, e[0], 1'b0}, `CCF_RESP_OKAY);
        sync_ev <= 1'b1;
        @(posedge clk);
        sync_ev <= 1'b0;
        rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
        `CHK("sync flag", e[0], d[`CCF_S_SYNC])
      end
      // request raised and dropped by the host, answered by clear-active
      wr(`CCF_OFS_CTRL, 32'h0000_0006, `CCF_RESP_OKAY);
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("clearing", 4'b0001, d[9:6])
      wr(`CCF_OFS_CTRL, 32'h0000_0002, `CCF_RESP_OKAY);
      rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
      `CHK("clear done", 1'b0, d[`CCF_S_CLR_ACT])
      // pass 0 keeps output one on through the clear, pass 1 only comparator one's input
      for (int m = 0; m < 3; m++)
      begin
        cmp_on <= 2'(2 >> m);
        wr(`CCF_OFS_CTRL, {27'h0, {2{m == 0}}, 3'h2}, `CCF_RESP_OKAY);
        wr(`CCF_OFS_CTRL, {27'h0, {2{m == 0}}, 3'h6}, `CCF_RESP_OKAY);
        wr(`CCF_OFS_CTRL, 32'h0000_0002, `CCF_RESP_OKAY);
        rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
        `CHK("cmp flags", 2'(2 >> m) | {1'b0, m == 0}, d[8:7])
      end
      $display("done flags");
    end
  endtask

  task automatic t_faults();
    logic [31:0] d;
    int          base;
    begin
      for (int k = 0; k < 4; k++)
      begin
        wr(`CCF_OFS_CTRL, 32'h0001_0000, `CCF_RESP_OKAY);
        base = n_diag;
        src[k] <= 1'b1;
        // acknowledge while the cause is still present must not clear
        wr(`CCF_OFS_CTRL, 32'h0001_0080, `CCF_RESP_OKAY);
        wr(`CCF_OFS_CTRL, 32'h0001_0000, `CCF_RESP_OKAY);
        src[k] <= 1'b0;
        rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
        `CHK("sticky", 1'b1, d[k])
        `CHK("diag", (k == 0), n_diag - base)
        wr(`CCF_OFS_CTRL, 32'h0001_0080, `CCF_RESP_OKAY);
        wr(`CCF_OFS_CTRL, 32'h0001_0000, `CCF_RESP_OKAY);
        rd(`CCF_OFS_STATUS, d, `CCF_RESP_OKAY);
        `CHK("acked", 1'b0, d[k])
      end
      $display("done faults");
    end
  endtask

  initial
  begin
    rstn = 1'b0;
    sync_ev = 1'b0;
    src = 4'h0;
    cmp_on = 2'h0;
    n_errors = 0;
    num_checks = 0;
    n_load = 0;
    n_diag = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_loads();
    t_param();
    t_outputs();
    t_flags();
    t_faults();
    summarize();
  end
endmodule

`default_nettype wire
